/* File: hdl/pbc_consts.svh */
// Offsets, field positions, reset values and codes of the power budgeting registers
`ifndef PBC_CONSTS_SVH
`define PBC_CONSTS_SVH

`define PBC_ADDR_W 12
`define PBC_OFS_HDR 12'h20C
`define PBC_OFS_SEL 12'h210
`define PBC_OFS_DATA 12'h214
`define PBC_OFS_FLAG 12'h218

`define PBC_CAP_ID 16'h0004
`define PBC_CAP_VER 4'h1
`define PBC_NEXT_UP 12'h230
`define PBC_NEXT_DN 12'h220

`define PBC_IDX_RST 8'h00
`define PBC_IDX_MAX 8'h00
`define PBC_IDX_SUST 8'h01

`define PBC_BASE_RST 8'h04
`define PBC_SCALE_RST 2'b00
`define PBC_SUB_RST 3'b000
`define PBC_PMST_RST 2'b00
`define PBC_TYPE_MAX 3'b111
`define PBC_TYPE_SUST 3'b000
`define PBC_RAIL_RST 3'b010
`define PBC_SYS_RST 1'b0

`define PBC_BASE_LSB 0
`define PBC_BASE_MSB 7
`define PBC_SCALE_LSB 8
`define PBC_SCALE_MSB 9
`define PBC_PMST_LSB 13
`define PBC_PMST_MSB 14
`define PBC_SYS_BIT 0

`define PBC_SETTLE_CYC 2'd3

`endif

/* File: hdl/pbc_pkg.sv */
// Types shared by the power budgeting register bank
package pbc_pkg;

  // Which stored value an override load targets
  typedef enum logic [1:0] {
    PBC_LD_MAX,
    PBC_LD_SUST,
    PBC_LD_SYS,
    PBC_LD_NONE
  } pbc_load_e;

  // Default override from the serial management or EEPROM loader
  typedef struct packed {
    logic valid;
    pbc_load_e target;
    logic [31:0] data;
  } pbc_load_s;

  // One power budget record in data register layout
  typedef struct packed {
    logic [10:0] rsvd;
    logic [2:0] rail;
    logic [2:0] condType;
    logic [1:0] pmState;
    logic [2:0] subState;
    logic [1:0] scale;
    logic [7:0] basePower;
  } pbc_rec_s;

endpackage

/* File: hdl/pbc_record_store.sv */
// Power budget records with default overrides and an indexed, registered read
`timescale 1ns/100ps
`include "pbc_consts.svh"

module pbc_record_store (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] index,
  input wire pbc_pkg::pbc_load_s load,
  output logic [31:0] recWord,
  output logic sysAlloc
);
  import pbc_pkg::*;

  logic [31:0] recWord_d;
  logic sysAlloc_d;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gRec
      localparam logic [2:0] TYPE_RST = (g == 0) ? `PBC_TYPE_MAX : `PBC_TYPE_SUST;
      localparam pbc_load_e TGT = (g == 0) ? PBC_LD_MAX : PBC_LD_SUST;
      pbc_rec_s rec_q;
      pbc_rec_s rec_d;

      always_comb
      begin
        rec_d = rec_q;
        // Only base power, scale and state accept an override
        if (load.valid && load.target == TGT)
        begin
          rec_d.basePower = load.data[`PBC_BASE_MSB:`PBC_BASE_LSB];
          rec_d.scale = load.data[`PBC_SCALE_MSB:`PBC_SCALE_LSB];
          rec_d.pmState = load.data[`PBC_PMST_MSB:`PBC_PMST_LSB];
        end
      end

      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          rec_q.rsvd <= '0;
          rec_q.rail <= `PBC_RAIL_RST;
          rec_q.condType <= TYPE_RST;
          rec_q.pmState <= `PBC_PMST_RST;
          rec_q.subState <= `PBC_SUB_RST;
          rec_q.scale <= `PBC_SCALE_RST;
          rec_q.basePower <= `PBC_BASE_RST;
        end
        else
          rec_q <= rec_d;
      end
    end
  endgenerate

  always_comb
  begin
    // Unsupported index reads as a zero budget
    if (index == `PBC_IDX_MAX)
      recWord_d = gRec[0].rec_q;
    else if (index == `PBC_IDX_SUST)
      recWord_d = gRec[1].rec_q;
    else
      recWord_d = '0;
    sysAlloc_d = sysAlloc;
    if (load.valid && load.target == PBC_LD_SYS)
      sysAlloc_d = load.data[`PBC_SYS_BIT];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      recWord <= '0;
      sysAlloc <= `PBC_SYS_RST;
    end
    else
    begin
      recWord <= recWord_d;
      sysAlloc <= sysAlloc_d;
    end
  end

endmodule

/* File: hdl/pbc_power_budget_regs.sv */
// APB register bank for the power budgeting extended capability of one port
//
// What this block does
// - The header's low 16 bits read 0004h, the power budgeting capability code.
// - The header's bits 19:16 read the fixed capability version 1h.
// - On the upstream port the header's next pointer reads 230h.
// - On a downstream port the header's next pointer reads 220h.
// - The select register holds a writable 8-bit record index that resets to 00h.
// - Index 00h makes the data register show the D0 maximum power record.
// - Index 01h makes the data register show the D0 sustained power record.
// - Any other index makes the data register read a zero budget.
// - Data bits 7:0 hold base power in watts, reset 04h, overridable by the loader.
// - Data bits 9:8 hold the scale, reset 00b, overridable by the loader.
// - Data bits 12:10 hold the sub-state, reset 000b.
// - Data bits 14:13 hold the power state, reset 00b (D0), overridable by the loader.
// - Data bits 17:15 hold the condition type, reset 111b for maximum power.
// - Data bits 20:18 hold the power rail, reset 010b.
// - Flag register bit 0 shows system allocation, reset 0b, loadable by the loader.
`timescale 1ns/100ps
`include "pbc_consts.svh"

module pbc_power_budget_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic upstreamStrap,
  input wire pbc_pkg::pbc_load_s loadPort
);
  import pbc_pkg::*;

  // Strap capture: the pin is asynchronous and settles after reset
  logic strapMeta_q;
  logic strapMeta_d;
  logic strapSync_q;
  logic strapSync_d;
  logic [1:0] settle_q;
  logic [1:0] settle_d;
  logic upstream_q;
  logic upstream_d;

  always_comb
  begin
    strapMeta_d = upstreamStrap;
    strapSync_d = strapMeta_q;
    settle_d = settle_q;
    upstream_d = upstream_q;
    // Latched once so a glitching strap cannot move the pointer later
    if (settle_q != `PBC_SETTLE_CYC)
    begin
      settle_d = settle_q + 2'd1;
      upstream_d = strapSync_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      strapMeta_q <= 1'b0;
      strapSync_q <= 1'b0;
      settle_q <= 2'd0;
      upstream_q <= 1'b0;
    end
    else
    begin
      strapMeta_q <= strapMeta_d;
      strapSync_q <= strapSync_d;
      settle_q <= settle_d;
      upstream_q <= upstream_d;
    end
  end

  // Record storage and indexed read
  logic [7:0] index_q;
  logic [7:0] index_d;
  logic [31:0] recWord;
  logic sysAlloc;

  pbc_record_store uStore (
    .clk(clk),
    .rst_n(rst_n),
    .index(index_q),
    .load(loadPort),
    .recWord(recWord),
    .sysAlloc(sysAlloc)
  );

  // Address decode, one aligned word per register
  logic access;
  logic hitHdr;
  logic hitSel;
  logic hitData;
  logic hitFlag;
  logic hitAny;
  logic [11:0] nextPtr;
  logic [31:0] readMux;

  always_comb
  begin
    // One wait state keeps prdata registered and lets the record settle
    access = psel && penable && !pready;
    hitHdr = paddr[11:2] == `PBC_OFS_HDR >> 2;
    hitSel = paddr[11:2] == `PBC_OFS_SEL >> 2;
    hitData = paddr[11:2] == `PBC_OFS_DATA >> 2;
    hitFlag = paddr[11:2] == `PBC_OFS_FLAG >> 2;
    hitAny = hitHdr || hitSel || hitData || hitFlag;
    nextPtr = upstream_q ? `PBC_NEXT_UP : `PBC_NEXT_DN;
    readMux = '0;
    if (hitHdr)
      readMux = {nextPtr, `PBC_CAP_VER, `PBC_CAP_ID};
    else if (hitSel)
      readMux = {24'h000000, index_q};
    else if (hitData)
      readMux = recWord;
    else if (hitFlag)
      readMux = {31'h00000000, sysAlloc};
  end

  // APB answer and the select register
  logic [31:0] prdata_d;
  logic pready_d;
  logic pslverr_d;

  always_comb
  begin
    pready_d = access;
    pslverr_d = access && !hitAny;
    prdata_d = '0;
    if (access && !pwrite)
      prdata_d = readMux;
    index_d = index_q;
    if (access && pwrite && hitSel)
      index_d = pwdata[7:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      index_q <= `PBC_IDX_RST;
    end
    else
    begin
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
      index_q <= index_d;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_hdr_ident: assert property (
    access && !pwrite && hitHdr |=> pready && prdata[15:0] == `PBC_CAP_ID)
    else $error("header capability code wrong");

  a_hdr_version: assert property (
    access && !pwrite && hitHdr |=> prdata[19:16] == `PBC_CAP_VER)
    else $error("header version wrong");

  a_next_upstream: assert property (
    access && !pwrite && hitHdr && upstream_q |=> prdata[31:20] == `PBC_NEXT_UP)
    else $error("upstream next pointer wrong");

  a_next_downstream: assert property (
    access && !pwrite && hitHdr && !upstream_q |=> prdata[31:20] == `PBC_NEXT_DN)
    else $error("downstream next pointer wrong");

  a_sel_readback: assert property (
    access && pwrite && hitSel ##2 psel && !penable && !pwrite && hitSel
      |=> ##1 prdata == {24'h000000, $past(pwdata[7:0], 4)})
    else $error("select register readback wrong");

  a_max_record: assert property (
    access && !pwrite && hitData && index_q == `PBC_IDX_MAX && $stable(index_q)
      |=> prdata[17:15] == `PBC_TYPE_MAX && prdata[20:18] == `PBC_RAIL_RST
          && prdata[12:10] == `PBC_SUB_RST)
    else $error("maximum record fields wrong");

  a_sust_record: assert property (
    access && !pwrite && hitData && index_q == `PBC_IDX_SUST && $stable(index_q)
      |=> prdata[17:15] == `PBC_TYPE_SUST && prdata[20:18] == `PBC_RAIL_RST)
    else $error("sustained record fields wrong");

  a_zero_budget: assert property (
    access && !pwrite && hitData && index_q > `PBC_IDX_SUST && $stable(index_q)
      |=> prdata == 32'h00000000)
    else $error("unsupported index not zero");

  a_ro_ignore: assert property (
    access && pwrite && !hitSel |=> $stable(index_q) && pready && prdata == 32'h00000000)
    else $error("write to read-only register had effect");

  a_data_rsvd: assert property (
    access && !pwrite && hitData |=> prdata[31:21] == 11'h000)
    else $error("data reserved bits not zero");

  a_flag_rsvd: assert property (
    access && !pwrite && hitFlag |=> prdata[31:1] == 31'h00000000 && prdata[0] == $past(sysAlloc))
    else $error("flag register wrong");

  a_rec_follow: assert property (
    $changed(index_q) |=> recWord[17:15] == ((index_q == `PBC_IDX_MAX) ? `PBC_TYPE_MAX :
      (index_q == `PBC_IDX_SUST) ? `PBC_TYPE_SUST : 3'b000))
    else $error("record did not follow index");

  a_one_wait: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("ready not a single pulse");

  // Between answers the read bus rests at zero, so a stale word cannot leak
  a_idle_quiet: assert property (
    !pready |-> prdata == 32'h00000000 && !pslverr)
    else $error("read bus not quiet between answers");

  a_err_unmapped: assert property (
    access && !hitAny |=> pready && pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");

  a_err_mapped: assert property (
    access && hitAny |=> pready && !pslverr)
    else $error("mapped access flagged as error");

  a_sel_write: assert property (
    access && pwrite && hitSel |=> index_q == $past(pwdata[7:0]))
    else $error("index write did not land");

  a_sel_rsvd: assert property (
    access && !pwrite && hitSel |=> prdata[31:8] == 24'h000000)
    else $error("select reserved bits not zero");

  a_sub_fixed: assert property (
    access && !pwrite && hitData && index_q <= `PBC_IDX_SUST
      |=> prdata[12:10] == `PBC_SUB_RST)
    else $error("sub-state field wrong");

  a_rail_fixed: assert property (
    access && !pwrite && hitData && index_q <= `PBC_IDX_SUST
      |=> prdata[20:18] == `PBC_RAIL_RST)
    else $error("power rail field wrong");

  a_zero_record: assert property (
    index_q > `PBC_IDX_SUST && $stable(index_q) |=> recWord == 32'h00000000)
    else $error("record word not zero for unsupported index");

  // Overrides reach the word two edges after the load: one for the store, one for the read
  a_base_load: assert property (
    loadPort.valid && loadPort.target == PBC_LD_MAX && index_q == `PBC_IDX_MAX
      && !(access && pwrite && hitSel)
      |=> ##1 recWord[`PBC_BASE_MSB:`PBC_BASE_LSB]
        == $past(loadPort.data[`PBC_BASE_MSB:`PBC_BASE_LSB], 2))
    else $error("base power override lost");

  a_scale_load: assert property (
    loadPort.valid && loadPort.target == PBC_LD_MAX && index_q == `PBC_IDX_MAX
      && !(access && pwrite && hitSel)
      |=> ##1 recWord[`PBC_SCALE_MSB:`PBC_SCALE_LSB]
        == $past(loadPort.data[`PBC_SCALE_MSB:`PBC_SCALE_LSB], 2))
    else $error("scale override lost");

  a_state_load: assert property (
    loadPort.valid && loadPort.target == PBC_LD_MAX && index_q == `PBC_IDX_MAX
      && !(access && pwrite && hitSel)
      |=> ##1 recWord[`PBC_PMST_MSB:`PBC_PMST_LSB]
        == $past(loadPort.data[`PBC_PMST_MSB:`PBC_PMST_LSB], 2))
    else $error("power state override lost");

  a_sys_load: assert property (
    loadPort.valid && loadPort.target == PBC_LD_SYS
      |=> sysAlloc == $past(loadPort.data[`PBC_SYS_BIT]))
    else $error("system allocated override lost");

  // The pointer must not follow a strap that moves after it was latched
  a_strap_hold: assert property (
    settle_q == `PBC_SETTLE_CYC |=> $stable(upstream_q) && $stable(settle_q))
    else $error("port direction moved after latching");

endmodule

/* File: tb/pbc_power_budget_regs_tb.sv */
// Self-checking bench for the power budgeting register bank
`timescale 1ns/100ps
`include "pbc_consts.svh"

module pbc_power_budget_regs_tb;
  import pbc_pkg::*;
  localparam logic [31:0] MAXD = 32'h000B_8004;
  localparam logic [31:0] SUSD = 32'h0008_0004;
  localparam logic [31:0] MSK = 32'h0000_63FF;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic upstreamStrap = 1'b1;
  pbc_load_s loadPort = '{1'b0, PBC_LD_NONE, 32'h0};
  int errors = 0;
  int compares = 0;
  logic [33:0] expQ[$];
  logic [31:0] r1;
  logic [31:0] r2;
  logic [31:0] d;
  logic [33:0] e;

  pbc_power_budget_regs dut (
    .clk(clk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .upstreamStrap(upstreamStrap),
    .loadPort(loadPort)
  );

  initial
  begin
    forever #10 clk = ~clk;
  end

  task automatic end_of_test();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask

  // Note layout: check data, error expected, data
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     input logic [33:0] x);
    int n;
    expQ.push_back(x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      errors++;
      end_of_test();
    end
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, {2'b10, x});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd, 34'h0);
  endtask

  // Releasing psel apart from the transfer keeps back-to-back requests glitch free
  task automatic idle();
    psel <= 1'b0;
    @(posedge clk);
  endtask

  task automatic ld(input pbc_load_e t, input logic [31:0] v);
    loadPort <= '{1'b1, t, v};
    @(posedge clk);
    loadPort <= '{1'b0, PBC_LD_NONE, 32'h0};
    repeat (2) @(posedge clk);
  endtask

  task automatic reset_dut();
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  always @(posedge clk)
  begin
    if (pready === 1'b1)
    begin
      if (expQ.size() == 0)
        chk(32'h1, 32'h0);
      else
      begin
        e = expQ.pop_front();
        chk({31'h0, pslverr}, {31'h0, e[32]});
        if (e[33])
          chk(prdata, e[31:0]);
      end
    end
  end

  initial
  begin
    void'($urandom(69));
    reset_dut();
    rd(`PBC_OFS_HDR, {`PBC_NEXT_UP, `PBC_CAP_VER, `PBC_CAP_ID});
    rd(`PBC_OFS_SEL, 32'h0);
    rd(`PBC_OFS_DATA, MAXD);
    rd(`PBC_OFS_FLAG, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      d = $urandom;
      if (i < 2)
        d[7:0] = i[7:0];
      wr(`PBC_OFS_SEL, d);
      rd(`PBC_OFS_DATA, d[7:0] == 8'h00 ? MAXD : d[7:0] == 8'h01 ? SUSD : 32'h0);
      rd(`PBC_OFS_SEL, {24'h0, d[7:0]});
    end
    wr(`PBC_OFS_SEL, d ^ 32'h0000_00FF);
    rd(`PBC_OFS_SEL, {24'h0, ~d[7:0]});
    wr(`PBC_OFS_SEL, 32'h0);
    wr(`PBC_OFS_HDR, $urandom);
    wr(`PBC_OFS_DATA, $urandom);
    wr(`PBC_OFS_FLAG, 32'hFFFF_FFFF);
    rd(`PBC_OFS_HDR, {`PBC_NEXT_UP, `PBC_CAP_VER, `PBC_CAP_ID});
    rd(`PBC_OFS_DATA, MAXD);
    rd(`PBC_OFS_FLAG, 32'h0);
    apb(1'b0, 12'h21C, 32'h0, {2'b11, 32'h0});
    apb(1'b1, 12'h000, $urandom, {2'b01, 32'h0});
    rd(`PBC_OFS_SEL, 32'h0);
    idle();
    r1 = $urandom;
    r2 = $urandom;
    ld(PBC_LD_NONE, 32'hFFFF_FFFF);
    ld(PBC_LD_MAX, r1);
    ld(PBC_LD_SUST, r2);
    ld(PBC_LD_SYS, 32'hFFFF_FFFF);
    rd(`PBC_OFS_DATA, (MAXD & ~MSK) | (r1 & MSK));
    wr(`PBC_OFS_SEL, 32'h1);
    rd(`PBC_OFS_DATA, (SUSD & ~MSK) | (r2 & MSK));
    rd(`PBC_OFS_FLAG, 32'h1);
    idle();
    upstreamStrap <= 1'b0;
    reset_dut();
    rd(`PBC_OFS_HDR, {`PBC_NEXT_DN, `PBC_CAP_VER, `PBC_CAP_ID});
    rd(`PBC_OFS_DATA, MAXD);
    rd(`PBC_OFS_FLAG, 32'h0);
    idle();
    repeat (2) @(posedge clk);
    end_of_test();
  end
endmodule
